// >>> brt_defines.svh
/*
 * constants of the ring and pitch generator block: register indexes,
 * reset values, response codes, phase decode and timing counts.
 * assumes a 200 MHz aclk and a slower auxiliary clock on a pin.
 */
//
// Behaviour
// - ring period setting five bits, read back
// - phase readback shows running phase counter
// - bit 3 gates alternate pitch pin only
// - bit 2 ring mode, always driven
// - bell mode bit 1 drives hiz phases
// - bit 0 runs counters, clear holds F
// - reset: output tristate, phase zero
// - two independent square generators, half duty
// - alternate pitch also modulates ring output
// - new divisor takes effect next cycle
// - switch and total time in 102.4us steps
// - first divisor until switch, repeat total
// - pitch is aux clock over divisor*128
// - zero divisor disables, output low
// - alternate divisor bits 9..0 read/write
// - first dual divisor bits 9..0 read/write
// - second dual divisor bits 9..0 read/write
// - sixteen phases of (period+1) 125us ticks
// - switch zero second, switch>=total first
// - zero total holds; end waits output low
`ifndef BRT_DEFINES_SVH
`define BRT_DEFINES_SVH

// register indexes; byte address is four times the index
`define BRT_IDX_F1     32'h01ff80b0
`define BRT_IDX_ALT    32'h01ff80b2
`define BRT_IDX_CTRL   32'h01ff80b4
`define BRT_IDX_PER    32'h01ff80b6
`define BRT_IDX_PHASE  32'h01ff80b8
`define BRT_IDX_F2     32'h01ff80ba
`define BRT_IDX_SW     32'h01ff80bc
`define BRT_IDX_TOT    32'h01ff80be

`define BRT_RST_DIV    10'h000
`define BRT_RST_PER    5'h00
`define BRT_RST_CTRL   4'h0
`define BRT_RST_PHASE  4'h0

`define BRT_PH_F       4'hf
`define BRT_PH_HI_LO   4'h1
`define BRT_PH_HI_HI   4'h6
`define BRT_PH_LO_LO   4'h9
`define BRT_PH_LO_HI   4'he

`define BRT_RESP_OKAY  2'b00
`define BRT_RESP_SLV   2'b10

`define BRT_CLK_NS     5
`define BRT_STEP_NS    102400
`define BRT_TICK_NS    125000
// 8*8 auxiliary edges per divisor count, times 2 half periods
`define BRT_PRE_LAST   6'h3f

`endif

// >>> brt_pkg.sv
/*
 * types of the ring and pitch generator block.
 * assumes the constants header for all figures.
 */
package brt_pkg;

    typedef struct packed {
        logic [9:0] div;
        logic [9:0] cnt;
        logic       out;
    } brt_tone_t;

    typedef struct packed {
        logic alt_gate;
        logic ring_mode;
        logic drive;
        logic run;
    } brt_ctrl_t;

endpackage : brt_pkg

// >>> brt_bell_tone.sv
/*
 * ring generator with phase counter, dual pitch generator and
 * alternate pitch generator behind an AXI4-Lite register slave.
 * assumes the auxiliary clock is below a quarter of aclk.
 */
`timescale 1ns/10ps
`include "brt_defines.svh"

module brt_bell_tone #(
    parameter logic [15:0] STEP_CYC = 16'(`BRT_STEP_NS / `BRT_CLK_NS),
    parameter logic [15:0] TICK_CYC = 16'(`BRT_TICK_NS / `BRT_CLK_NS)
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        auxiliary_clock_input,
    output      logic        ring_pin_level,
    output      logic        ring_pin_oe,
    output      logic        alternate_pitch_output,
    output      logic        dual_pitch_output
);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    function automatic logic is_reg(input logic [31:0] idx, input logic [31:0] base);
        is_reg = (idx[31:1] == base[31:1]);
    endfunction : is_reg

    function automatic logic [9:0] put10(input logic [9:0] old, input logic hi,
                                         input logic [7:0] b);
        put10 = hi ? {b[1:0], old[7:0]} : {old[9:8], b};
    endfunction : put10

    // one step of a half-duty square generator; divisor reloads at cycle start
    function automatic brt_pkg::brt_tone_t tone_step(input brt_pkg::brt_tone_t s,
                                                     input logic [9:0] req,
                                                     input logic tick);
        brt_pkg::brt_tone_t n;
        n = s;
        if (req == 10'h000)
        begin
            n.div = 10'h000;
            n.cnt = 10'h000;
            n.out = 1'b0;
        end
        else if (s.div == 10'h000 && tick)  // start on a prescaler tick so the first high is whole
        begin
            n.div = req;
            n.cnt = 10'h000;
            n.out = 1'b1;
        end
        else if (tick)
        begin
            if (s.cnt == s.div - 10'h001)
            begin
                n.cnt = 10'h000;
                n.out = ~s.out;
                if (!s.out)
                begin
                    n.div = req;
                end
            end
            else
            begin
                n.cnt = s.cnt + 10'h001;
            end
        end
        tone_step = n;
    endfunction : tone_step

    // registers
    logic [9:0]         f1_q, alt_div_q, f2_q, sw_q, tot_q;
    logic [4:0]         per_q;
    brt_pkg::brt_ctrl_t ctrl_q;
    logic [3:0]         phase_q;

    // bus slave state
    logic               aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [31:0]        aw_idx_q;
    logic [7:0]         w_byte_q;
    logic               w_en_q;
    logic [1:0]         bresp_q, rresp_q;
    logic [31:0]        rdata_q;

    wire  [31:0] ar_idx  = {2'b00, s_axi_araddr[31:2]};
    wire         aw_take = s_axi_awvalid && s_axi_awready;
    wire         w_take  = s_axi_wvalid && s_axi_wready;
    wire         ar_take = s_axi_arvalid && s_axi_arready;
    wire         do_wr   = aw_have_q && w_have_q && !bvalid_q;
    wire         wr_hi   = aw_idx_q[0];

    function automatic logic hit_any(input logic [31:0] idx);
        hit_any = (idx[31:4] == 28'(`BRT_IDX_F1 >> 4));
    endfunction : hit_any

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    wire wr_ok   = do_wr && w_en_q;
    wire wr_f1   = wr_ok && is_reg(aw_idx_q, `BRT_IDX_F1);
    wire wr_alt  = wr_ok && is_reg(aw_idx_q, `BRT_IDX_ALT);
    wire wr_f2   = wr_ok && is_reg(aw_idx_q, `BRT_IDX_F2);
    wire wr_sw   = wr_ok && is_reg(aw_idx_q, `BRT_IDX_SW);
    wire wr_tot  = wr_ok && is_reg(aw_idx_q, `BRT_IDX_TOT);
    // upper halves of period and control hold nothing
    wire wr_per  = wr_ok && !wr_hi && is_reg(aw_idx_q, `BRT_IDX_PER);
    wire wr_ctrl = wr_ok && !wr_hi && is_reg(aw_idx_q, `BRT_IDX_CTRL);

    // read word, then byte by index parity; unused bits zero
    wire [15:0] rd_word =
        is_reg(ar_idx, `BRT_IDX_F1)    ? {6'h00, f1_q}      :
        is_reg(ar_idx, `BRT_IDX_ALT)   ? {6'h00, alt_div_q} :
        is_reg(ar_idx, `BRT_IDX_CTRL)  ? {12'h000, ctrl_q}  :
        is_reg(ar_idx, `BRT_IDX_PER)   ? {11'h000, per_q}   :
        is_reg(ar_idx, `BRT_IDX_PHASE) ? {12'h000, phase_q} :
        is_reg(ar_idx, `BRT_IDX_F2)    ? {6'h00, f2_q}      :
        is_reg(ar_idx, `BRT_IDX_SW)    ? {6'h00, sw_q}      :
        is_reg(ar_idx, `BRT_IDX_TOT)   ? {6'h00, tot_q}     : 16'h0000;
    wire [7:0]  rd_byte = ar_idx[0] ? rd_word[15:8] : rd_word[7:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_idx_q  <= 32'h0000_0000;
            w_byte_q  <= 8'h00;
            w_en_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `BRT_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= {2'b00, s_axi_awaddr[31:2]};
            end
            if (w_take)
            begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_en_q   <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= hit_any(aw_idx_q) ? `BRT_RESP_OKAY : `BRT_RESP_SLV;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `BRT_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= hit_any(ar_idx) ? `BRT_RESP_OKAY : `BRT_RESP_SLV;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            f1_q      <= `BRT_RST_DIV;
            alt_div_q <= `BRT_RST_DIV;
            f2_q      <= `BRT_RST_DIV;
            sw_q      <= `BRT_RST_DIV;
            tot_q     <= `BRT_RST_DIV;
            per_q     <= `BRT_RST_PER;
            ctrl_q    <= `BRT_RST_CTRL;
        end
        else
        begin
            if (wr_f1)   f1_q      <= put10(f1_q, wr_hi, w_byte_q);
            if (wr_alt)  alt_div_q <= put10(alt_div_q, wr_hi, w_byte_q);
            if (wr_f2)   f2_q      <= put10(f2_q, wr_hi, w_byte_q);
            if (wr_sw)   sw_q      <= put10(sw_q, wr_hi, w_byte_q);
            if (wr_tot)  tot_q     <= put10(tot_q, wr_hi, w_byte_q);
            if (wr_per)  per_q     <= w_byte_q[4:0];
            if (wr_ctrl) ctrl_q    <= w_byte_q[3:0];
        end
    end

    // auxiliary clock: a pin, so two flops before the edge detector
    logic       aux_s1_q, aux_s2_q, aux_s3_q;
    logic [5:0] pre_q;
    wire        aux_tick = aux_s2_q && !aux_s3_q;
    wire        pre_tick = aux_tick && (pre_q == `BRT_PRE_LAST);

    // dual pitch timing
    logic [15:0]        step_q;
    logic [9:0]         t_q;
    brt_pkg::brt_tone_t alt_q, dual_q;
    wire at_end    = (t_q >= tot_q);
    wire held      = at_end && !dual_q.out;
    wire step_tick = (step_q == STEP_CYC - 16'h0001);
    wire [9:0] dual_req = (t_q < sw_q) ? f1_q : f2_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aux_s1_q <= 1'b0;
            aux_s2_q <= 1'b0;
            aux_s3_q <= 1'b0;
            pre_q    <= 6'h00;
            step_q   <= 16'h0000;
            t_q      <= 10'h000;
            alt_q    <= '0;
            dual_q   <= '0;
        end
        else
        begin
            aux_s1_q <= auxiliary_clock_input;
            aux_s2_q <= aux_s1_q;
            aux_s3_q <= aux_s2_q;
            if (aux_tick) pre_q <= pre_q + 6'h01;
            alt_q <= tone_step(alt_q, alt_div_q, pre_tick);
            // reset of the pattern waits for a low output so no high is cut
            if (held)
            begin
                step_q <= 16'h0000;
                t_q    <= 10'h000;
                dual_q <= '0;
            end
            else
            begin
                step_q <= step_tick ? 16'h0000 : step_q + 16'h0001;
                if (step_tick && !at_end) t_q <= t_q + 10'h001;
                dual_q <= tone_step(dual_q, dual_req, pre_tick);
            end
        end
    end

    // ring generator
    logic [15:0] tick_q;
    logic [4:0]  pc_q;
    logic        run_prev_q, gate_q;
    logic        ring_o_q, ring_oe_q, alt_o_q, dual_o_q;
    wire bell_tick = (tick_q == TICK_CYC - 16'h0001);
    wire ph_hi     = (phase_q >= `BRT_PH_HI_LO) && (phase_q <= `BRT_PH_HI_HI);
    wire ph_lo     = (phase_q >= `BRT_PH_LO_LO) && (phase_q <= `BRT_PH_LO_HI);
    wire hiz_ph    = !ph_hi && !ph_lo;
    // window moves only while the modulation is low
    wire gate_d    = alt_q.out ? gate_q : (ctrl_q.run && ph_hi);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_q     <= 16'h0000;
            pc_q       <= 5'h00;
            phase_q    <= `BRT_RST_PHASE;
            run_prev_q <= 1'b0;
            gate_q     <= 1'b0;
        end
        else
        begin
            run_prev_q <= ctrl_q.run;
            gate_q     <= gate_d;
            if (ctrl_q.run)
            begin
                tick_q <= bell_tick ? 16'h0000 : tick_q + 16'h0001;
                if (bell_tick)
                begin
                    pc_q <= (pc_q == per_q) ? 5'h00 : pc_q + 5'h01;
                    if (pc_q == per_q) phase_q <= phase_q + 4'h1;
                end
            end
            else
            begin
                tick_q <= 16'h0000;
                pc_q   <= 5'h00;
                if (run_prev_q) phase_q <= `BRT_PH_F;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ring_o_q  <= 1'b0;
            ring_oe_q <= 1'b0;
            alt_o_q   <= 1'b0;
            dual_o_q  <= 1'b0;
        end
        else
        begin
            ring_o_q  <= ctrl_q.ring_mode ? (gate_q && alt_q.out) : ph_hi;
            ring_oe_q <= ctrl_q.ring_mode || ctrl_q.drive || !hiz_ph;
            alt_o_q   <= ctrl_q.alt_gate && alt_q.out;
            dual_o_q  <= dual_q.out;
        end
    end

    assign ring_pin_level         = ring_o_q;
    assign ring_pin_oe            = ring_oe_q;
    assign alternate_pitch_output = alt_o_q;
    assign dual_pitch_output      = dual_o_q;

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pattern_wrap;
        (t_q != 10'h000) ##1 (t_q == 10'h000);
    endsequence

    a_reset_tristate: assert property ($past(!aresetn) |-> phase_q == `BRT_RST_PHASE && !ring_pin_oe)
        else $error("ring pin not tristate at phase zero after reset");
    a_ring_drive: assert property (ctrl_q.ring_mode |=> ring_pin_oe)
        else $error("ring mode left the pin undriven");
    a_bell_hiz: assert property (!ctrl_q.ring_mode && !ctrl_q.drive && hiz_ph |=> !ring_pin_oe)
        else $error("bell pin driven in a tristate phase");
    a_alt_pin_gate: assert property (!ctrl_q.alt_gate |=> !alternate_pitch_output)
        else $error("alternate pitch pin not forced low");
    a_stop_phase_f: assert property ($fell(ctrl_q.run) |=> phase_q == `BRT_PH_F)
        else $error("stopped counter not at phase F");
    a_phase_step: assert property ($changed(phase_q) && $past(ctrl_q.run) |-> $past(bell_tick && pc_q == per_q))
        else $error("phase moved off a period boundary");
    a_div_at_start: assert property ($changed(alt_q.div) && $past(alt_q.div) != 10'h000 && alt_q.div != 10'h000 |-> $past(!alt_q.out) && alt_q.out)
        else $error("divisor changed inside a pitch cycle");
    a_alt_off_low: assert property (alt_div_q == 10'h000 |=> !alt_q.out ##1 !alternate_pitch_output)
        else $error("disabled generator not low");
    a_wrap_when_low: assert property (s_pattern_wrap |-> $past(!dual_q.out))
        else $error("pattern end cut a high half");
    a_ring_whole: assert property ($changed(gate_q) |-> $past(!alt_q.out))
        else $error("ring window moved during a modulation high");
    a_wr_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
        else $error("write answer not two cycles after both channels");
    a_period_read: assert property (ar_take && is_reg(ar_idx, `BRT_IDX_PER) && !ar_idx[0] |=> s_axi_rvalid && s_axi_rdata == {27'h0000000, $past(per_q)})
        else $error("period setting not read back");

endmodule : brt_bell_tone

// >>> brt_pin_model.sv
/*
 * pin-side partner: free-running auxiliary clock source and a ring pin
 * load with a weak pull-down.
 * assumes the bench wires it to the generator's pin ports.
 */
`timescale 1ns/10ps

module brt_pin_model #(
    parameter real AUX_HALF = 20.0
) (
    output logic      aux_clk,
    input  wire logic ring_drive,
    input  wire logic ring_oe,
    output logic      ring_level,
    output logic      ring_hiz
);
    // odd start offset keeps aux unrelated in phase to aclk
    initial
    begin
        aux_clk = 1'b0;
        #3.7;
        forever #(AUX_HALF) aux_clk = ~aux_clk;
    end

    // a released pin falls to the pull-down level, never keeps the last value
    assign ring_level = ring_oe ? ring_drive : 1'b0;
    assign ring_hiz   = !ring_oe;
endmodule : brt_pin_model

// >>> brt_bell_tone_tb.sv
/*
 * self-checking bench of the ring and pitch generator block: register
 * access over AXI4-Lite, bell and ring pin patterns, pitch timing.
 * assumes the pin model for the auxiliary clock and the pin load.
 */
`timescale 1ns/10ps
`include "brt_defines.svh"

module brt_bell_tone_tb;
    localparam int         TICK = 16;
    localparam int         STEP = 64;
    localparam int         HALF = 512;  // 64 aux periods of 40 ns per count
    localparam int         LIM  = 20000;
    localparam logic [1:0] OK   = `BRT_RESP_OKAY;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] araddr = '0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        aux, ring_o, ring_oe, alt_o, dual_o, ring_lvl, ring_hiz;
    int          bad_count = 0;
    int          compares = 0;
    int          hi, lo, n_hi, n_lo, n_z, n_alt, n_dual;
    bit          s1, s2, odd;
    logic [31:0] t_idx [10] = '{`BRT_IDX_F1, `BRT_IDX_F1 + 1, `BRT_IDX_ALT, `BRT_IDX_ALT + 1,
        `BRT_IDX_F2, `BRT_IDX_F2 + 1, `BRT_IDX_PER, `BRT_IDX_PER + 1, `BRT_IDX_CTRL + 1,
        `BRT_IDX_PHASE};
    logic [7:0]  t_exp [10] = '{8'hff, 8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'h1f, 8'h00,
        8'h00, 8'h00};

    always #2.5 aclk = ~aclk;

    brt_bell_tone #(
        .STEP_CYC (16'(STEP)),
        .TICK_CYC (16'(TICK))
    ) dut (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .s_axi_awaddr          (awaddr),
        .s_axi_awprot          (3'h0),
        .s_axi_awvalid         (awvalid),
        .s_axi_awready         (awready),
        .s_axi_wdata           (wdata),
        .s_axi_wstrb           (4'h1),
        .s_axi_wvalid          (wvalid),
        .s_axi_wready          (wready),
        .s_axi_bresp           (bresp),
        .s_axi_bvalid          (bvalid),
        .s_axi_bready          (bready),
        .s_axi_araddr          (araddr),
        .s_axi_arprot          (3'h0),
        .s_axi_arvalid         (arvalid),
        .s_axi_arready         (arready),
        .s_axi_rdata           (rdata),
        .s_axi_rresp           (rresp),
        .s_axi_rvalid          (rvalid),
        .s_axi_rready          (rready),
        .auxiliary_clock_input (aux),
        .ring_pin_level        (ring_o),
        .ring_pin_oe           (ring_oe),
        .alternate_pitch_output(alt_o),
        .dual_pitch_output     (dual_o)
    );

    brt_pin_model load (
        .aux_clk   (aux),
        .ring_drive(ring_o),
        .ring_oe   (ring_oe),
        .ring_level(ring_lvl),
        .ring_hiz  (ring_hiz)
    );

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input logic ok_in, input string msg);
        compares++;
        if (ok_in !== 1'b1)
        begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic wr(input logic [31:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= {idx[29:0], 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        chk(bvalid === 1'b1 && bresp === er, $sformatf("write %h", idx));
        if (bvalid !== 1'b1)
            end_sim();
    endtask : wr

    task automatic rd(input logic [31:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= {idx[29:0], 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        chk(rvalid === 1'b1 && rdata === {24'h0, ed} && rresp === er, $sformatf("read %h", idx));
        if (rvalid !== 1'b1)
            end_sim();
    endtask : rd

    task automatic wait_lvl(input bit sel, input logic lvl, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge aclk);
            cnt++;
        end while ((sel ? dual_o : alt_o) !== lvl && cnt < LIM);
        chk(cnt < LIM, "pitch wait timeout");
        if (cnt >= LIM)
            end_sim();
    endtask : wait_lvl

    // whole high then whole low half, starting from a fresh rising edge
    task automatic meas(input bit sel, output int h, output int l);
        wait_lvl(sel, 1'b0, h);
        wait_lvl(sel, 1'b1, h);
        wait_lvl(sel, 1'b0, h);
        wait_lvl(sel, 1'b1, l);
    endtask : meas

    function automatic bit near(input int v, input int e);
        return v >= e - 2 && v <= e + 2;
    endfunction : near

    task automatic pins(input int cyc);
        {n_hi, n_lo, n_z, n_alt, n_dual} = '0;
        repeat (cyc)
        begin
            @(posedge aclk);
            n_z    += int'(ring_hiz === 1'b1);
            n_hi   += int'(ring_hiz === 1'b0 && ring_lvl === 1'b1);
            n_lo   += int'(ring_hiz === 1'b0 && ring_lvl === 1'b0);
            n_alt  += int'(alt_o === 1'b1);
            n_dual += int'(dual_o === 1'b1);
        end
    endtask : pins

    // counts over two whole periods are exact whatever the start phase
    task automatic bell(input logic [4:0] per, input logic drv);
        int p;
        p = (int'(per) + 1) * 16 * TICK;
        wr(`BRT_IDX_CTRL, 8'h00, OK);
        wr(`BRT_IDX_PER, {3'h0, per}, OK);
        wr(`BRT_IDX_CTRL, {6'h0, drv, 1'b1}, OK);
        repeat (p) @(posedge aclk);
        pins(2 * p);
        chk(n_hi == p * 3 / 4, "bell high share");
        chk(n_lo == (drv ? p * 5 / 4 : p * 3 / 4), "bell low share");
        chk(n_z == (drv ? 0 : p / 2), "bell released share");
    endtask : bell

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(ring_oe === 1'b0, "pin driven after reset");
        for (int i = 0; i < 16; i++)
            rd(`BRT_IDX_F1 + i, 8'h00, OK);
        $display("test reset done");

        for (int i = 0; i < 10; i++)
        begin
            wr(t_idx[i], 8'hff, OK);
            rd(t_idx[i], t_exp[i], OK);
        end
        for (int i = 0; i < 10; i++)
            wr(t_idx[i], 8'h00, OK);
        wr(`BRT_IDX_CTRL, 8'hfa, OK);
        rd(`BRT_IDX_CTRL, 8'h0a, OK);
        wr(32'h01ff80c0, 8'h11, `BRT_RESP_SLV);
        rd(32'h01ff80c0, 8'h00, `BRT_RESP_SLV);
        $display("test registers done");

        bell(5'h00, 1'b0);
        bell(5'h01, 1'b1);
        wr(`BRT_IDX_CTRL, 8'h00, OK);
        rd(`BRT_IDX_PHASE, 8'h0f, OK);
        chk(ring_hiz === 1'b1, "stopped bell still driven");
        $display("test bell done");

        // gate off: the ring output keeps its modulation, the pin stays low
        wr(`BRT_IDX_ALT, 8'h01, OK);
        wr(`BRT_IDX_PER, 8'h1f, OK);
        wr(`BRT_IDX_CTRL, 8'h05, OK);
        pins(2 * 32 * 16 * TICK);
        chk(n_z == 0, "ring mode released pin");
        chk(n_hi > 0, "ring output silent");
        chk(n_alt == 0, "ungated pitch on pin");
        wr(`BRT_IDX_CTRL, 8'h0d, OK);
        meas(1'b0, hi, lo);
        chk(near(hi, HALF) && near(lo, HALF), "alt half period");
        wr(`BRT_IDX_ALT, 8'h02, OK);
        meas(1'b0, hi, lo);
        chk(near(hi, lo) && (near(hi, HALF) || near(hi, 2 * HALF)), "change glitch");
        meas(1'b0, hi, lo);
        chk(near(hi, 2 * HALF) && near(lo, 2 * HALF), "new half period");
        wr(`BRT_IDX_ALT, 8'h00, OK);
        repeat (3) @(posedge aclk);
        pins(4 * HALF);
        chk(n_alt == 0, "zero divisor still toggles");
        chk(n_hi == 0, "ring pulses without source");
        $display("test alternate done");

        wr(`BRT_IDX_F1, 8'h01, OK);
        wr(`BRT_IDX_F2, 8'h02, OK);
        pins(4 * HALF);
        chk(n_dual == 0, "zero total not held low");
        wr(`BRT_IDX_TOT, 8'h64, OK);
        meas(1'b1, hi, lo);
        chk(near(hi, 2 * HALF), "zero switch not second pitch");
        wr(`BRT_IDX_SW, 8'hc8, OK);
        meas(1'b1, hi, lo);
        meas(1'b1, hi, lo);
        chk(near(hi, HALF), "long switch not first pitch");
        wr(`BRT_IDX_SW, 8'h32, OK);
        {s1, s2, odd} = '0;
        repeat (6)
        begin
            meas(1'b1, hi, lo);
            s1 |= near(hi, HALF);
            s2 |= near(hi, 2 * HALF);
            odd |= !near(hi, HALF) && !near(hi, 2 * HALF);
        end
        chk(s1 && s2, "dual pattern lacks a pitch");
        chk(!odd, "truncated high pulse");
        $display("test dual done");
        end_sim();
    end
endmodule : brt_bell_tone_tb
